// >>> src/gpio_pkg.sv
// register map and field layout of the parallel i/o ports
`default_nettype none
package gpio_pkg;
  // register indices (byte address is four times the index)
  localparam logic [3:0] porta_latch_idx = 4'h0;
  localparam logic [3:0] portb_latch_idx = 4'h1;
  localparam logic [3:0] portc_latch_idx = 4'h2;
  localparam logic [3:0] porta_dir_idx = 4'h4;
  localparam logic [3:0] portb_dir_idx = 4'h5;
  localparam logic [3:0] portc_dir_idx = 4'h6;
  localparam logic [3:0] analog_ctrl_idx = 4'h8;
  // field layout
  localparam int porta_width = 8;
  localparam int portb_width = 8;
  localparam int portc_width = 6;
  localparam int clock_out_pin = 2;
  localparam int clock_output_enable_bit = 7;
  localparam int analog_select_width = 5;
  // analog select codes at or above this pick no port b pin
  localparam logic [4:0] analog_none_code = 5'h08;
  // reset values
  localparam logic [7:0] dir_reset = 8'h00;
  localparam logic [4:0] analog_select_reset = 5'h1F;
endpackage
`default_nettype wire

// >>> src/pin_sync.sv
// three-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int width = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins in, clean level out
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] level
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  // shift chain; only stage2 reads stage1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < width; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/parallel_io_ports_abc.sv
// parallel i/o ports a, b and c with ahb-lite register access
// Contract
// - port a has eight pins, each made input or output by its own direction bit.
// - every pin has a data latch that software writes and reads and reset leaves alone.
// - a direction bit of 1 drives the latch onto the pin, 0 leaves the pin undriven.
// - reset clears all direction bits of ports a and b so their pins start as inputs.
// - reading port a data gives the latch for output bits and the pin level for input bits.
// - writing port data always loads the latches but never changes an input pin or its read value.
// - reading port b data gives the latch for output bits and the pin level for input bits.
// - the port b pin picked by the analog channel select is forced to an undriven analog input.
// - port b pins not picked as analog channel act as ordinary digital i/o.
// - port c has six pins, each with its own latch and direction bit.
// - port c pin 2 can output the system clock, enabled by a bit in the port c direction register.
// - with the clock output enable set, port c pin 2 drives the system clock; reset clears it.
// - reading port c data gives the latch for output bits and the pin level for input bits.
// - reset clears the six port c direction bits so every port c pin starts as an input.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_abc (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port a pins
  input wire logic [7:0] porta_pin_in,
  output logic [7:0] porta_pin_out,
  output logic [7:0] porta_pin_oe,
  // port b pins
  input wire logic [7:0] portb_pin_in,
  output logic [7:0] portb_pin_out,
  output logic [7:0] portb_pin_oe,
  // port b pin currently routed to the analog converter
  output logic [7:0] analog_channel_pin,
  // port c pins
  input wire logic [5:0] portc_pin_in,
  output logic [5:0] portc_pin_out,
  output logic [5:0] portc_pin_oe,
  // system clock to be shown on port c pin 2
  input wire logic system_clock
);

  ////////////////////////////////////////////////////////////////////////////
  // behaviour in brief
  // registers sit one word apart: the byte address is four times the index
  // unaligned or out-of-range addresses: writes dropped, reads give zero
  // hsize is not decoded; only whole-word transfers are expected
  // a write commits one edge after its address phase, using hwdata
  // read data are registered at the address phase edge, with no wait state
  // a read straight after a write to the same register shows the old value;
  // software that must see the new one leaves an idle cycle between them
  // pin levels pass four flops before the read mux, so a pin change shows
  // in read data about five edges later
  // data latches have no reset; an output bit reads unknown until written
  // direction bits and the clock output enable clear on reset
  // an analog pick on port b masks both drive and enable of that pin, and
  // the pin then reads through its direction bit like any other
  // with the clock output on, port c pin 2 drives whatever its direction bit
  // the forwarded clock passes through logic only, no flop on its path
  // load a latch before switching its pin to output, or the old latch value
  // shows on the pin until the write lands

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] porta_latch;
  logic [7:0] portb_latch;
  logic [5:0] portc_latch;
  logic [7:0] porta_dir;
  logic [7:0] portb_dir;
  logic [5:0] portc_dir;
  logic clock_output_enable;
  logic [4:0] analog_channel_select;
  logic [7:0] porta_level;
  logic [7:0] portb_level;
  logic [5:0] portc_level;
  logic wr_pend;
  logic [3:0] wr_idx;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic take = hsel && hready && htrans[1];
  wire logic word_ok = (haddr[1:0] == 2'h0) && (haddr[31:6] == 26'h0);
  wire logic [3:0] addr_idx = haddr[5:2];
  wire logic [3:0] rd_idx = addr_idx;
  // writes land one cycle after the address phase, with hwdata
  wire logic do_write = wr_pend;

  // one write strobe per register, from the captured index
  wire logic wr_porta_latch = do_write && (wr_idx == gpio_pkg::porta_latch_idx);
  wire logic wr_portb_latch = do_write && (wr_idx == gpio_pkg::portb_latch_idx);
  wire logic wr_portc_latch = do_write && (wr_idx == gpio_pkg::portc_latch_idx);
  wire logic wr_porta_dir = do_write && (wr_idx == gpio_pkg::porta_dir_idx);
  wire logic wr_portb_dir = do_write && (wr_idx == gpio_pkg::portb_dir_idx);
  wire logic wr_portc_dir = do_write && (wr_idx == gpio_pkg::portc_dir_idx);
  wire logic wr_analog = do_write && (wr_idx == gpio_pkg::analog_ctrl_idx);

  // one read select per register, from the live address phase
  wire logic rd_porta_latch = (rd_idx == gpio_pkg::porta_latch_idx);
  wire logic rd_portb_latch = (rd_idx == gpio_pkg::portb_latch_idx);
  wire logic rd_portc_latch = (rd_idx == gpio_pkg::portc_latch_idx);
  wire logic rd_porta_dir = (rd_idx == gpio_pkg::porta_dir_idx);
  wire logic rd_portb_dir = (rd_idx == gpio_pkg::portb_dir_idx);
  wire logic rd_portc_dir = (rd_idx == gpio_pkg::portc_dir_idx);
  wire logic rd_analog = (rd_idx == gpio_pkg::analog_ctrl_idx);
  // read address phase taken
  wire logic rd_any = take && !hwrite;

  // capture a write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 4'h0;
    end else begin
      wr_pend <= take && hwrite && word_ok;
      wr_idx <= addr_idx;
    end
  end

  // zero wait state, always okay; every register is one flop or mux away,
  // so the slave never has to stretch a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // port a levels
  pin_sync #(.width(8)) sync_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(porta_pin_in),
    .level(porta_level)
  );

  // port b levels
  pin_sync #(.width(8)) sync_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(portb_pin_in),
    .level(portb_level)
  );

  // port c levels
  pin_sync #(.width(6)) sync_c (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(portc_pin_in),
    .level(portc_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data latches, no reset

  // port a latch loads on any write regardless of direction; no reset,
  // so an output bit reads unknown until software has written it
  always_ff @(posedge hclk) begin
    if (wr_porta_latch) begin
      porta_latch <= hwdata[7:0];
    end
  end

  // port b latch
  always_ff @(posedge hclk) begin
    if (wr_portb_latch) begin
      portb_latch <= hwdata[7:0];
    end
  end

  // port c latch, six bits
  always_ff @(posedge hclk) begin
    if (wr_portc_latch) begin
      portc_latch <= hwdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction and control registers

  // port a direction, reset to all inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      porta_dir <= gpio_pkg::dir_reset;
    end else if (wr_porta_dir) begin
      porta_dir <= hwdata[7:0];
    end
  end

  // port b direction, reset to all inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portb_dir <= gpio_pkg::dir_reset;
    end else if (wr_portb_dir) begin
      portb_dir <= hwdata[7:0];
    end
  end

  // port c direction and the clock output enable share one register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portc_dir <= gpio_pkg::dir_reset[5:0];
      clock_output_enable <= 1'b0;
    end else if (wr_portc_dir) begin
      portc_dir <= hwdata[5:0];
      clock_output_enable <= hwdata[gpio_pkg::clock_output_enable_bit];
    end
  end

  // analog channel select; its reset value picks no port b pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_channel_select <= gpio_pkg::analog_select_reset;
    end else if (wr_analog) begin
      analog_channel_select <= hwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  // analog pick: one-hot of the selected port b pin
  wire logic analog_on = analog_channel_select < gpio_pkg::analog_none_code;
  assign analog_channel_pin = analog_on ? (8'h01 << analog_channel_select[2:0]) : 8'h00;

  // port a follows its direction bits
  assign porta_pin_out = porta_latch;
  assign porta_pin_oe = porta_dir;

  // port b: analog pick overrides direction
  assign portb_pin_out = portb_latch & ~analog_channel_pin;
  assign portb_pin_oe = portb_dir & ~analog_channel_pin;

  // port c: pin 2 can carry the system clock
  wire logic [5:0] clk_mask = 6'h01 << gpio_pkg::clock_out_pin;
  // clock pin mask, live only while the clock output is enabled
  wire logic [5:0] clk_pick = clock_output_enable ? clk_mask : 6'h00;
  // system clock placed on the clock pin position
  wire logic [5:0] clk_bits = system_clock ? clk_pick : 6'h00;
  // latch bits everywhere except where the clock takes over
  wire logic [5:0] portc_latch_bits = portc_latch & ~clk_pick;
  assign portc_pin_out = portc_latch_bits | clk_bits;
  assign portc_pin_oe = portc_dir | clk_pick;

  ////////////////////////////////////////////////////////////////////////////
  // read back

  // port a: latch for output bits, synchronised pin for input bits
  wire logic [7:0] porta_out_bits = porta_latch & porta_dir;
  wire logic [7:0] porta_in_bits = porta_level & ~porta_dir;
  wire logic [7:0] porta_view = porta_out_bits | porta_in_bits;

  // port b: same mix; an analog pick reads through its direction bit
  wire logic [7:0] portb_out_bits = portb_latch & portb_dir;
  wire logic [7:0] portb_in_bits = portb_level & ~portb_dir;
  wire logic [7:0] portb_view = portb_out_bits | portb_in_bits;

  // port c: same mix over six bits
  wire logic [5:0] portc_out_bits = portc_latch & portc_dir;
  wire logic [5:0] portc_in_bits = portc_level & ~portc_dir;
  wire logic [5:0] portc_view = portc_out_bits | portc_in_bits;

  // each register padded to a bus word, unused bits read zero
  wire logic [31:0] porta_word = {24'h0, porta_view};
  wire logic [31:0] portb_word = {24'h0, portb_view};
  wire logic [31:0] portc_word = {26'h0, portc_view};
  wire logic [31:0] porta_dir_word = {24'h0, porta_dir};
  wire logic [31:0] portb_dir_word = {24'h0, portb_dir};
  wire logic [31:0] portc_dir_word = {24'h0, clock_output_enable, 1'b0, portc_dir};
  wire logic [31:0] analog_word = {27'h0, analog_channel_select};

  // read select; holes in the map read zero
  wire logic [31:0] rd_mux =
    rd_porta_latch ? porta_word :
    rd_portb_latch ? portb_word :
    rd_portc_latch ? portc_word :
    rd_porta_dir ? porta_dir_word :
    rd_portb_dir ? portb_dir_word :
    rd_portc_dir ? portc_dir_word :
    rd_analog ? analog_word :
    32'h0;

  // read data registered for the data phase; it holds until the next read
  // is taken, so idle cycles do not disturb it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_any) begin
      hrdata <= word_ok ? rd_mux : 32'h0;
    end
  end

endmodule
`default_nettype wire

// >>> sim/pio_board.sv
// board circuitry behind one port
`timescale 1ns/1ps
`default_nettype none
module pio_board #(parameter int width = 8) (
  input wire logic [width-1:0] out, oe, ext,
  output logic [width-1:0] level
);
  // driven pins show the latch, undriven ones the board level
  assign level = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

// >>> sim/parallel_io_ports_abc_properties.sv
// assertions on the bus and pins of the i/o ports
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_abc_properties (
  input wire logic hclk, hresetn, hsel, hwrite, hready,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [7:0] porta_pin_out, porta_pin_oe, portb_pin_oe, analog_channel_pin,
  input wire logic [5:0] portc_pin_oe
);
  // address phase taken, and the write case of it
  wire tk = hsel && hready && htrans[1];
  wire wr = tk && hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RST_OE: assert property ($rose(hresetn) |->
    {porta_pin_oe, portb_pin_oe, portc_pin_oe} == 22'h0) else $error("pin driven after reset");
  AST_ONE_CHANNEL: assert property ($onehot0(analog_channel_pin))
    else $error("several analog pins");
  AST_ANALOG_FREE: assert property ((portb_pin_oe & analog_channel_pin) == 8'h00)
    else $error("analog pin driven");
  AST_DIR_A: assert property (wr && haddr == 32'h10 |=> ##1
    porta_pin_oe == $past(hwdata[7:0])) else $error("port a enable wrong");
  AST_DIR_C: assert property (wr && haddr == 32'h18 |=> ##1
    portc_pin_oe == ($past(hwdata[5:0]) | {3'h0, $past(hwdata[7]), 2'h0}))
    else $error("port c enable wrong");
  AST_LATCH_A: assert property (wr && haddr == 32'h00 |=> ##1
    porta_pin_out == $past(hwdata[7:0])) else $error("port a latch wrong");
  AST_OE_CAUSE: assert property ($changed(porta_pin_oe) |-> $past(wr && haddr == 32'h10, 2))
    else $error("enable moved without write");
  AST_READ_HIGH: assert property (tk && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read upper bits set");
endmodule
bind parallel_io_ports_abc parallel_io_ports_abc_properties u_parallel_io_ports_abc_properties (.*);
`default_nettype wire

// >>> sim/parallel_io_ports_abc_test.sv
// self-checking bench for the parallel i/o ports
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_abc_test;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, m;
  logic [7:0] a_out, a_oe, b_out, b_oe, an, a_lvl, b_lvl, ext_a = 8'h5A, ext_b = 8'hC3;
  logic [5:0] c_out, c_oe, c_lvl, ext_c = 6'h2D;
  int failures = 0, n_checks = 0;
  typedef struct {logic [31:0] a, d, e;} row_t;
  row_t rows [7] = '{'{32'h10, 32'h0F, 32'h0F}, '{32'h00, 32'h33, 32'h53},
    '{32'h14, 32'hF0, 32'hF0}, '{32'h04, 32'h99, 32'h93}, '{32'h18, 32'h55, 32'h15},
    '{32'h08, 32'h3E, 32'h3C}, '{32'h3C, 32'hFF, 32'h00}};
  // clock
  always #2.5 hclk = ~hclk;
  parallel_io_ports_abc u_parallel_io_ports_abc (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .porta_pin_in(a_lvl), .porta_pin_out(a_out), .porta_pin_oe(a_oe),
    .portb_pin_in(b_lvl), .portb_pin_out(b_out), .portb_pin_oe(b_oe),
    .analog_channel_pin(an), .portc_pin_in(c_lvl), .portc_pin_out(c_out),
    .portc_pin_oe(c_oe), .system_clock(hclk));
  pio_board u_pio_board_a (.out(a_out), .oe(a_oe), .ext(ext_a), .level(a_lvl));
  pio_board u_pio_board_b (.out(b_out), .oe(b_oe), .ext(ext_b), .level(b_lvl));
  pio_board #(.width(6)) u_pio_board_c (.out(c_out), .oe(c_oe), .ext(ext_c), .level(c_lvl));
  // verdict
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string n, logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // wait for hready under a bound
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      close_out;
    end
  endtask
  // one single ahb-lite transfer
  task automatic xfer(logic w, logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check("oe", {10'h0, a_oe, b_oe, c_oe}, 32'h0);
  endtask
  // main sequence
  initial begin
    do_reset;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      check("register", rd, rows[i].e);
      check("resp", {31'h0, hresp}, 32'h0);
    end
    $display("test table done");
    for (int k = 0; k < 9; k++) begin
      xfer(1'b1, 32'h20, 32'(k));
      @(negedge hclk);
      m = (k < 8) ? 32'h1 << k : 32'h0;
      check("analog", {24'h0, an}, m);
      check("b oe", {24'h0, b_oe}, 32'hF0 & ~m);
      check("b out", {24'h0, b_out}, 32'h99 & ~m);
    end
    $display("test analog done");
    xfer(1'b1, 32'h18, 32'h80);
    @(negedge hclk);
    check("clk oe", {26'h0, c_oe}, 32'h4);
    check("clk lo", {31'h0, c_out[2]}, 32'h0);
    @(posedge hclk);
    #1;
    check("clk hi", {31'h0, c_out[2]}, 32'h1);
    $display("test clock done");
    do_reset;
    xfer(1'b1, 32'h10, 32'hFF);
    xfer(1'b0, 32'h00, 32'h0);
    check("kept", rd, 32'h33);
    xfer(1'b1, 32'h10, 32'h00);
    xfer(1'b1, 32'h00, 32'hAA);
    xfer(1'b0, 32'h00, 32'h0);
    check("input", rd, 32'h5A);
    xfer(1'b1, 32'h10, 32'hFF);
    xfer(1'b0, 32'h00, 32'h0);
    check("latch", rd, 32'hAA);
    check("pin", {24'h0, a_lvl}, 32'hAA);
    $display("test reset done");
    close_out;
  end
endmodule
`default_nettype wire
